// ### bench/ebh_master.sv
// model of the outside master that borrows the memory port
`timescale 1ns/10ps
module ebh_master (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// bench wish and hold pins
	input wire logic want,
	input wire logic bus_hold_grant_n,
	output logic hold_req_n
);
	logic seen_r; // grant seen low at an earlier edge

	// request follows the wish, changed just after an edge
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hold_req_n <= 1'b1;
			seen_r <= 1'b0;
		end else begin
			seen_r <= !bus_hold_grant_n;
			if (want) begin
				hold_req_n <= 1'b0;
			end else if (bus_hold_grant_n || seen_r) begin
				hold_req_n <= 1'b1;
			end
		end
	end
endmodule

// ### bench/tb.sv
// testbench: hold handshake against the master model
`timescale 1ns/10ps
module tb;
	localparam int PW = $bits(ebh_pkg::ebh_port_t);
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic want = 1'b0; // master wants the port
	logic hold_req_n;
	logic bus_hold_grant_n;
	logic hold_stall;
	logic hold_disable_bit = 1'b0;
	logic burst_eight_priority_bit = 1'b0;
	logic xfer_busy = 1'b0;
	logic sdram_access_done = 1'b0;
	logic async_ready_input = 1'b1;
	ebh_pkg::ebh_port_t port_in = '1;
	ebh_pkg::ebh_port_t port_out;
	ebh_pkg::ebh_port_oe_t port_oe;
	int err_count = 0;
	int checks = 0;
	int nf;
	int ng;
	logic [31:0] rnd = 32'h1d6c; // scenario lengths
	logic [31:0] prnd = 32'h1d6c; // pin data

	always #10 clk_sys = ~clk_sys;

	ebh_master ebh_master_i (.clk_sys(clk_sys), .resetn(resetn), .want(want),
		.bus_hold_grant_n(bus_hold_grant_n), .hold_req_n(hold_req_n));
	ebh_hold ebh_hold_i (.clk_sys(clk_sys), .resetn(resetn),
		.hold_req_n(hold_req_n), .bus_hold_grant_n(bus_hold_grant_n),
		.hold_disable_bit(hold_disable_bit),
		.burst_eight_priority_bit(burst_eight_priority_bit),
		.xfer_busy(xfer_busy), .sdram_access_done(sdram_access_done),
		.async_ready_input(async_ready_input), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe), .hold_stall(hold_stall));

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction
	// idle latency: master edge, two sync stages, minimum float
	function automatic int exp_nf();
		return ebh_pkg::RELEASE_MIN_CYC + 2;
	endfunction
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_cnt(input string nm, input int e, input int g);
		checks++;
		if (g != e) begin
			err_count++;
			$display("[ERR] %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic chk_port(input ebh_pkg::ebh_port_t e);
		checks++;
		if (port_out !== e) begin
			err_count++;
			$display("[ERR] port_out exp %h got %h", e, port_out);
		end
	endtask
	task automatic chk_oe(input logic drv);
		checks++;
		if (port_oe !== {$bits(port_oe){drv}}) begin
			err_count++;
			$display("[ERR] port_oe exp all %b got %h", drv, port_oe);
		end
	endtask
	// edges until pins and grant both reach the wanted level
	task automatic lat(input logic drv, output int f, output int g);
		int n;
		n = 0;
		f = 0;
		g = 0;
		while (n < 40 && (f == 0 || g == 0)) begin
			@(posedge clk_sys);
			#1;
			n++;
			if (f == 0 && port_oe === {$bits(port_oe){drv}}) f = n;
			if (g == 0 && bus_hold_grant_n === drv) g = n;
		end
		if (f == 0 || g == 0) begin
			err_count++;
			$display("[ERR] handshake exp done got timeout");
			close_out();
		end
	endtask
	// port must stay driven and ungranted
	task automatic hold_off(input int n);
		repeat (n) begin
			@(negedge clk_sys);
			chk_bit("grant_n", 1'b1, bus_hold_grant_n);
			chk_oe(1'b1);
		end
	endtask
	task automatic grab();
		lat(1'b0, nf, ng);
		chk_bit("gap", 1'b1, ng >= nf && ng - nf <= 2);
		chk_bit("hold_stall", 1'b1, hold_stall);
	endtask
	task automatic give(input string nm);
		int w;
		@(negedge clk_sys);
		want = 1'b0;
		// count the redrive from the edge that lifts the request pin
		w = 0;
		while (w < 8 && hold_req_n !== 1'b1) begin
			@(posedge clk_sys);
			#1;
			w++;
		end
		if (hold_req_n !== 1'b1) begin
			err_count++;
			$display("[ERR] hold_req_n exp 1 got %b", hold_req_n);
			close_out();
		end
		lat(1'b1, nf, ng);
		chk_bit("redrive", 1'b1, nf >= 3 && nf <= 7);
		chk_bit("gap", 1'b1, ng >= nf && ng - nf <= 2);
		chk_bit("hold_stall", 1'b0, hold_stall);
		$display("test %s done", nm);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// random pin data, registered copy checked every edge
	always @(negedge clk_sys) begin
		prnd = lfsr(prnd);
		port_in <= PW'({prnd, ~prnd, prnd});
		async_ready_input <= prnd[3];
	end
	always @(posedge clk_sys) begin
		#1;
		if (resetn) chk_port(port_in);
	end

	initial begin
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		// idle port, random hold lengths
		for (int i = 0; i < 3; i++) begin
			@(negedge clk_sys);
			want = 1'b1;
			grab();
			chk_cnt("float", exp_nf(), nf);
			repeat (rnd[1:0]) @(negedge clk_sys);
			rnd = lfsr(rnd);
			give("idle");
		end
		// transfer in flight delays the grant
		@(negedge clk_sys);
		xfer_busy = 1'b1;
		want = 1'b1;
		hold_off(8 + rnd[2:0]);
		xfer_busy = 1'b0;
		grab();
		give("busy");
		// burst priority: seven accesses are not enough
		@(negedge clk_sys);
		burst_eight_priority_bit = 1'b1;
		want = 1'b1;
		hold_off(4);
		repeat (7) begin
			sdram_access_done = 1'b1;
			hold_off(1);
			sdram_access_done = 1'b0;
			hold_off(1);
		end
		sdram_access_done = 1'b1;
		@(negedge clk_sys);
		sdram_access_done = 1'b0;
		grab();
		give("burst");
		// configuration only moves on the falling edge
		@(negedge clk_sys);
		burst_eight_priority_bit = 1'b0;
		// disable bit blocks the hold
		hold_disable_bit = 1'b1;
		want = 1'b1;
		hold_off(20);
		want = 1'b0;
		hold_off(10);
		hold_disable_bit = 1'b0;
		$display("test disable done");
		// request dropped while draining shows nothing
		xfer_busy = 1'b1;
		want = 1'b1;
		hold_off(6);
		want = 1'b0;
		hold_off(4);
		xfer_busy = 1'b0;
		hold_off(10);
		$display("test abort done");
		close_out();
	end
endmodule

// ### core/ebh_hold.sv
// external memory port hold request / grant handshake
// Function
// - release port no sooner than four cycles
// - grant within two cycles of release
// - redrive port three to seven cycles after
// - drop grant within two cycles of redrive
// - pending transactions finish before grant
// - burst priority holds off for eight accesses
// - idle port releases at minimum delay
// - hold disable bit blocks the grant
// - all memory port pins float together
`timescale 1ns/10ps
module ebh_hold (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// hold handshake pins
	input wire logic hold_req_n,
	output logic bus_hold_grant_n,
	// configuration
	input wire logic hold_disable_bit,
	input wire logic burst_eight_priority_bit,
	// memory controller status
	input wire logic xfer_busy,
	input wire logic sdram_access_done,
	input wire logic async_ready_input,
	// memory port from controller, out to pins
	input wire ebh_pkg::ebh_port_t port_in,
	output ebh_pkg::ebh_port_t port_out,
	output ebh_pkg::ebh_port_oe_t port_oe,
	// tells the controller to start nothing new
	output logic hold_stall
);
	////////////////////////////////////////////////////////////////
	// state record
	typedef struct packed {
		ebh_pkg::ebh_state_t st;
		logic [ebh_pkg::CNT_W-1:0] cnt;
		logic [ebh_pkg::CNT_W-1:0] burst;
		logic float_en;
		logic grant_n;
		ebh_pkg::ebh_port_t pins;
	} ebh_hold_state_t;

	ebh_hold_state_t s_r; // registered state
	ebh_hold_state_t s_nxt; // next state
	logic req_s; // synchronised request, active high
	logic req_n_s; // synchronised request pin

	////////////////////////////////////////////////////////////////
	// request crossing
	// two flop sync
	ebh_sync #(.RST_VAL(ebh_pkg::SYNC_RST)) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.d_async(hold_req_n),
		.q_sync(req_n_s)
	);
	assign req_s = ~req_n_s;

	////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		s_nxt = s_r;
		// pins follow the controller, registered
		s_nxt.pins = port_in;
		unique case (s_r.st)
			// port owned, waiting for a request
			ebh_pkg::EBH_OWN: begin
				s_nxt.cnt = '0;
				s_nxt.burst = '0;
				if (req_s && !hold_disable_bit) begin
					s_nxt.st = ebh_pkg::EBH_DRAIN;
					s_nxt.cnt = 4'(1);
				end
			end
			// waiting out the minimum and pending work
			ebh_pkg::EBH_DRAIN: begin
				if (s_r.cnt != '1)
					s_nxt.cnt = s_r.cnt + 4'(1);
				if (sdram_access_done && s_r.burst != '1)
					s_nxt.burst = s_r.burst + 4'(1);
				if (!req_s || hold_disable_bit) begin
					// request withdrawn or hold disabled before release
					s_nxt.st = ebh_pkg::EBH_OWN;
				end else if (s_r.cnt >= 4'(ebh_pkg::RELEASE_MIN_CYC - 2)
						&& !xfer_busy
						&& (!burst_eight_priority_bit
						|| s_r.burst >= 4'(ebh_pkg::BURST_MIN_LEN))) begin
					s_nxt.st = ebh_pkg::EBH_FLOAT;
					s_nxt.float_en = 1'b1;
				end
			end
			// port floating, grant next edge
			ebh_pkg::EBH_FLOAT: begin
				s_nxt.grant_n = 1'b0;
				s_nxt.st = ebh_pkg::EBH_HELD;
			end
			// master owns the port
			ebh_pkg::EBH_HELD: begin
				s_nxt.cnt = '0;
				if (!req_s) begin
					s_nxt.st = ebh_pkg::EBH_RETAKE;
					s_nxt.cnt = 4'(1);
				end
			end
			// counting toward redrive
			ebh_pkg::EBH_RETAKE: begin
				s_nxt.cnt = s_r.cnt + 4'(1);
				if (s_r.cnt >= 4'(ebh_pkg::DRIVE_MIN_CYC - 2)) begin
					s_nxt.float_en = 1'b0;
					s_nxt.st = ebh_pkg::EBH_DRIVEN;
				end
			end
			// driven again, drop grant
			ebh_pkg::EBH_DRIVEN: begin
				s_nxt.grant_n = 1'b1;
				s_nxt.st = ebh_pkg::EBH_OWN;
			end
			default: s_nxt.st = ebh_pkg::EBH_OWN;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_r.st <= ebh_pkg::EBH_OWN;
			s_r.cnt <= '0;
			s_r.burst <= '0;
			s_r.float_en <= 1'b0;
			s_r.grant_n <= ebh_pkg::GRANT_RST_N;
			s_r.pins <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	// one enable for every pin
	assign port_oe = {$bits(ebh_pkg::ebh_port_oe_t){~s_r.float_en}};
	assign port_out = s_r.pins;
	assign bus_hold_grant_n = s_r.grant_n;
	// keeps new work off the port once hold is pending
	assign hold_stall = (s_r.st != ebh_pkg::EBH_OWN);

	////////////////////////////////////////////////////////////////
	// checks
	logic float_q; // float enable one cycle back
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			float_q <= 1'b0;
		else
			float_q <= s_r.float_en;
	end
	wire float_rise = s_r.float_en && !float_q;
	wire float_fall = !s_r.float_en && float_q;

	property p_min_release;
		@(posedge clk_sys) disable iff (!resetn)
		$fell(hold_req_n) |-> (!s_r.float_en) [*4];
	endproperty
	a_min_release: assert property (p_min_release)
		else $error("port floated before four cycles");

	property p_grant_after_float;
		@(posedge clk_sys) disable iff (!resetn)
		float_rise |-> ##[0:2] !bus_hold_grant_n;
	endproperty
	a_grant_after_float: assert property (p_grant_after_float)
		else $error("grant late after float");

	property p_redrive_window;
		@(posedge clk_sys) disable iff (!resetn)
		($rose(hold_req_n) && s_r.st == ebh_pkg::EBH_HELD)
			|-> s_r.float_en [*3] ##[0:4] !s_r.float_en;
	endproperty
	a_redrive_window: assert property (p_redrive_window)
		else $error("redrive outside window");

	property p_drop_after_drive;
		@(posedge clk_sys) disable iff (!resetn)
		float_fall |-> ##[0:2] bus_hold_grant_n;
	endproperty
	a_drop_after_drive: assert property (p_drop_after_drive)
		else $error("grant held after redrive");

	property p_no_float_busy;
		@(posedge clk_sys) disable iff (!resetn)
		float_rise |-> !$past(xfer_busy);
	endproperty
	a_no_float_busy: assert property (p_no_float_busy)
		else $error("port floated with transfer pending");

	property p_burst_first;
		@(posedge clk_sys) disable iff (!resetn)
		(float_rise && $past(burst_eight_priority_bit))
			|-> $past(s_r.burst) >= 4'(ebh_pkg::BURST_MIN_LEN);
	endproperty
	a_burst_first: assert property (p_burst_first)
		else $error("released before eight bursts");

	property p_idle_min;
		@(posedge clk_sys) disable iff (!resetn)
		($fell(req_n_s) && !hold_disable_bit && !burst_eight_priority_bit)
			##1 (!xfer_busy && req_s && !hold_disable_bit) [*3]
			|-> s_r.float_en;
	endproperty
	a_idle_min: assert property (p_idle_min)
		else $error("idle port not released at minimum");

	property p_disable_blocks;
		@(posedge clk_sys) disable iff (!resetn)
		(hold_disable_bit && s_r.st == ebh_pkg::EBH_OWN)
			|=> s_r.st == ebh_pkg::EBH_OWN;
	endproperty
	a_disable_blocks: assert property (p_disable_blocks)
		else $error("hold started while disabled");

	property p_grant_floated;
		@(posedge clk_sys) disable iff (!resetn)
		// grant may trail the redrive by one cycle, so look one edge back
		!bus_hold_grant_n |-> (port_oe == '0 || $past(port_oe) == '0);
	endproperty
	a_grant_floated: assert property (p_grant_floated)
		else $error("pin driven while granted");

	property p_sync_delay;
		@(posedge clk_sys) disable iff (!resetn)
		$fell(hold_req_n) ##1 !hold_req_n |=> !req_n_s;
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("request sync delay wrong");

	c_grant: cover property (@(posedge clk_sys) disable iff (!resetn)
		$fell(bus_hold_grant_n));
	c_release: cover property (@(posedge clk_sys) disable iff (!resetn)
		$rose(bus_hold_grant_n));
	c_busy_wait: cover property (@(posedge clk_sys) disable iff (!resetn)
		s_r.st == ebh_pkg::EBH_DRAIN && xfer_busy);
	c_burst_wait: cover property (@(posedge clk_sys) disable iff (!resetn)
		float_rise && burst_eight_priority_bit);
endmodule

// ### core/ebh_pkg.sv
// package: constants and carrier types for the bus hold handshake
package ebh_pkg;
	// handshake delays in cpu clock cycles, burst length in accesses, sync depth and counter width
	localparam int RELEASE_MIN_CYC = 4;
	localparam int GRANT_MAX_CYC = 2;
	localparam int DRIVE_MIN_CYC = 3;
	localparam int DRIVE_MAX_CYC = 7;
	localparam int BURST_MIN_LEN = 8;
	localparam int SYNC_STAGES = 2;
	localparam int CNT_W = 4;
	// reset values
	localparam logic GRANT_RST_N = 1'b1;
	localparam logic SYNC_RST = 1'b1;
	// pin group widths
	localparam int CE_W = 4;
	localparam int BE_W = 4;
	localparam int ED_W = 32;
	localparam int EA_W = 20;
	// handshake phases
	typedef enum logic [2:0] {
		EBH_OWN,
		EBH_DRAIN,
		EBH_FLOAT,
		EBH_HELD,
		EBH_RETAKE,
		EBH_DRIVEN
	} ebh_state_t;
	// memory port pin group as driven by the core
	typedef struct packed {
		logic [CE_W-1:0] chip_selects_n;
		logic [BE_W-1:0] memory_byte_enables_n;
		logic [ED_W-1:0] memory_data_lines;
		logic [EA_W-1:0] memory_address_lines;
		logic async_read_strobe_n;
		logic async_output_enable_n;
		logic async_write_strobe_n;
		logic column_or_burst_address_strobe_n;
		logic row_strobe_or_sync_output_enable_n;
		logic sync_write_strobe_n;
		logic sdram_a10_line;
	} ebh_port_t;
	// per-pin output enables for the same group
	typedef struct packed {
		logic [CE_W-1:0] ce_oe;
		logic [BE_W-1:0] be_oe;
		logic [ED_W-1:0] ed_oe;
		logic [EA_W-1:0] ea_oe;
		logic [6:0] strobe_oe;
	} ebh_port_oe_t;
endpackage

// ### core/ebh_sync.sv
// two-stage synchroniser for the asynchronous hold request
`timescale 1ns/10ps
module ebh_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// async in, synchronised out
	input wire logic d_async,
	output logic q_sync
);
	// first stage is read only by the second
	logic meta_r;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_r <= RST_VAL;
			q_sync <= RST_VAL;
		end else begin
			meta_r <= d_async;
			q_sync <= meta_r;
		end
	end
endmodule
